// *** core/mfl_ctrl.sv ***
/*
  Controller end: divides mclk into the link clock, issues mode register
  sets and reads on request, captures returned data.
  Assumes user requests only while busy is low.
*/
`timescale 1ns/1ps
module mfl_ctrl
#(
  parameter int DQ_W = 8,
  parameter int DIV  = 4
) (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  mfl_link_if.ctrl                   link,
  input  wire logic                  req,
  input  wire logic [mfl_pkg::CMD_W-1:0] req_cmd,
  input  wire logic [mfl_pkg::BA_W-1:0]  req_ba,
  input  wire logic [mfl_pkg::ADR_W-1:0] req_adr,
  input  wire logic                  req_wlev,
  output logic                       busy,
  output logic [DQ_W-1:0]            rd_data,
  output logic                       rd_valid,
  output logic                       req_refused
);
  import mfl_pkg::*;

  logic [7:0]       div_q;
  logic             lclk_q;
  logic             pend_q;
  logic [CMD_W-1:0] cmd_q;
  logic [BA_W-1:0]  ba_q;
  logic [ADR_W-1:0] adr_q;
  logic             wlev_q;
  logic             calm_q;
  logic             ref_q;
  logic             oe_s1;
  logic             oe_s2;
  logic [DQ_W-1:0]  dq_s1;
  logic [DQ_W-1:0]  dq_s2;
  logic             fall;
  logic             rise_e;
  logic             seen_q;

  ////////////////////////////////////////////////////////////////////////
  // Link clock divider
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_q  <= '0;
      lclk_q <= 1'b0;
    end else if (div_q == 8'(DIV - 1)) begin
      div_q  <= '0;
      lclk_q <= ~lclk_q;
    end else begin
      div_q <= div_q + 8'h1;
    end
  end
  // Change lines at falling link edge so the device sees them stable
  assign fall = (div_q == 8'(DIV - 1)) && lclk_q;
  assign rise_e = (div_q == 8'(DIV - 1)) && !lclk_q;

  // A command taken in the high half would miss the device if dropped at
  // the next falling edge; hold it until one rising edge has carried it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seen_q <= 1'b0;
    end else if (req && !pend_q) begin
      seen_q <= rise_e;
    end else if (rise_e) begin
      seen_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request taking; sanitise MRS fields before issue
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
      cmd_q  <= CMD_NOP;
      ba_q   <= '0;
      adr_q  <= '0;
      wlev_q <= 1'b0;
      calm_q <= 1'b0;
      ref_q  <= 1'b0;
    end else begin
      ref_q <= 1'b0;
      if (req && !pend_q) begin
        // only reads or MR3 set while in pattern mode
        // no mode register load during a read burst
        if ((calm_q && !(req_cmd == CMD_RD || req_cmd == CMD_RDAP ||
                         (req_cmd == CMD_MRS && req_ba == BA_MR3))) ||
            (req_cmd == CMD_MRS && oe_s2)) begin
          ref_q <= 1'b1;
        end else begin
          pend_q <= 1'b1;
          ba_q   <= req_ba;
          wlev_q <= req_wlev;
          cmd_q  <= req_cmd;
          adr_q  <= req_adr;
          if (req_cmd == CMD_MRS && req_ba == BA_MR3) begin
            adr_q  <= {{(ADR_W-MR3_SRC_BIT-1){1'b0}}, req_adr[MR3_SRC_BIT:0]};
            calm_q <= req_adr[MR3_SRC_BIT];
          end else if (req_cmd == CMD_MRS && req_ba == BA_MR2 &&
                       req_adr[MR2_AUTO_BIT]) begin
            adr_q <= req_adr & ~(ADR_W'(1) << MR2_FORCE_BIT);
          end else if (calm_q && (req_cmd == CMD_RD || req_cmd == CMD_RDAP)) begin
            adr_q <= req_adr & ~((ADR_W'(1) << ADR_NIB_BIT) - ADR_W'(1));
          end
        end
      end else if (fall && pend_q && cmd_q != CMD_NOP && seen_q) begin
        // Hold over one rising link edge then drop to idle
        cmd_q <= CMD_NOP;
      end else if (fall && pend_q && cmd_q == CMD_NOP) begin
        pend_q <= 1'b0;
      end
    end
  end
  assign busy          = pend_q;
  assign req_refused   = ref_q;
  assign link.lclk     = lclk_q;
  assign link.cmd      = cmd_q;
  assign link.ba       = ba_q;
  assign link.adr      = adr_q;
  assign link.wlev     = wlev_q;

  ////////////////////////////////////////////////////////////////////////
  // Read capture through two stages
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      oe_s1    <= 1'b0;
      oe_s2    <= 1'b0;
      dq_s1    <= '0;
      dq_s2    <= '0;
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      oe_s1    <= link.dq_dev_oe;
      oe_s2    <= oe_s1;
      dq_s1    <= link.dq_dev;
      dq_s2    <= dq_s1;
      rd_valid <= oe_s2 && fall;
      if (oe_s2 && fall) begin
        rd_data <= dq_s2;
      end
    end
  end
endmodule : mfl_ctrl

// *** core/mfl_dev.sv ***
/*
  Device end: mode registers 2 and 3 feature logic. Self-refresh rate,
  dynamic write termination, calibration pattern readout.
  Assumes commands sampled on rising link clock edges seen through mclk;
  link clock made by the controller from the same mclk.
*/
// Behaviour
// - MR2 bit 6 enables automatic rate
// - Both off gives 1x rate
// - Automatic: 2x above temperature threshold
// - MR2 bit 7 enables forced rate
// - Forced option always gives 2x
// - Controller never sets both rate options
// - Controller refreshes faster when hot; this controller issues no refresh commands
// - MR2 bits 10:9 select write termination
// - Write value during burst, then nominal
// - Write value only in writes, independent
// - No write termination in write leveling
// - Controller loads MR3 idle, then waits
// - Controller zeroes reserved MR3 bits
// - MR3 bit 2 low: normal array access
// - MR3 bit 2 high: reads give pattern
// - Controller precharges before enabling pattern; this controller issues no precharge
// - Only reads in pattern mode; reset honoured
// - Pattern on prime line or all lines
// - Pattern as 8 beats or chopped 4
// - Address bit 2 selects chopped nibble
// - Burst bit 0 first, bit 7 last
// - Other address bits ignored; A12 chops
// - Pattern alternates starting with zero
// - Bank code 011 targets MR3
`timescale 1ns/1ps
module mfl_dev
#(
  parameter int DQ_W = 8
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  mfl_link_if.dev         link,
  input  wire logic       temp_over,
  input  wire logic       all_lines,
  input  wire logic [1:0] nominal_termination_value,
  input  wire logic       dll_locked,
  output logic [1:0]      refresh_rate,
  output logic [1:0]      term_active,
  output logic            cal_mode,
  output logic            cmd_illegal
);
  import mfl_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WR   = 3'b010,
    ST_RD   = 3'b100
  } mfl_dst_t;

  logic             lclk_s;
  logic             lclk_rise;
  logic             temp_s;
  logic             wlev_s;
  logic             temp_r;
  logic             wlev_r;
  logic [CMD_W-1:0] cmd_q;
  logic [BA_W-1:0]  ba_q;
  logic [ADR_W-1:0] adr_q;
  logic             auto_temp_refresh_rate_q;
  logic             forced_double_refresh_rate_q;
  logic [1:0]       write_termination_value_q;
  logic             src_q;
  logic [1:0]       sel_q;
  logic [1:0]       bl_q;
  mfl_dst_t         st_q;
  logic [3:0]       beat_q;
  logic [3:0]       nbeat_q;
  logic [2:0]       bidx_q;
  logic [DQ_W-1:0]  dq_q;
  logic             oe_q;
  logic             dqs_q;
  logic             ill_q;

  function automatic logic is_read(input logic [CMD_W-1:0] c);
    return (c == CMD_RD) || (c == CMD_RDAP);
  endfunction : is_read

  mfl_sync u_clk (.mclk(mclk), .sys_rst(sys_rst), .din(link.lclk),
                  .dout(lclk_s), .rise(lclk_rise));
  mfl_sync u_tmp (.mclk(mclk), .sys_rst(sys_rst), .din(temp_over),
                  .dout(temp_s), .rise());
  mfl_sync u_wl  (.mclk(mclk), .sys_rst(sys_rst), .din(link.wlev),
                  .dout(wlev_s), .rise());

  ////////////////////////////////////////////////////////////////////////
  // Command capture: link lines settle through two stages like the clock
  logic [CMD_W-1:0] cmd_s1;
  logic [BA_W-1:0]  ba_s1;
  logic [ADR_W-1:0] adr_s1;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmd_s1 <= CMD_NOP;
      ba_s1  <= '0;
      adr_s1 <= '0;
      cmd_q  <= CMD_NOP;
      ba_q   <= '0;
      adr_q  <= '0;
    end else begin
      cmd_s1 <= link.cmd;
      ba_s1  <= link.ba;
      adr_s1 <= link.adr;
      cmd_q  <= cmd_s1;
      ba_q   <= ba_s1;
      adr_q  <= adr_s1;
    end
  end
  assign temp_r = temp_s;
  assign wlev_r = wlev_s;

  ////////////////////////////////////////////////////////////////////////
  // Mode register loads
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      auto_temp_refresh_rate_q     <= 1'b0;
      forced_double_refresh_rate_q <= 1'b0;
      write_termination_value_q    <= TERM_OFF;
      src_q                        <= 1'b0;
      sel_q                        <= MR3_SEL_CAL;
      bl_q                         <= BL_FIX8;
    end else if (lclk_rise && cmd_q == CMD_MRS) begin
      if (ba_q == BA_MR2) begin
        auto_temp_refresh_rate_q     <= adr_q[MR2_AUTO_BIT];
        forced_double_refresh_rate_q <= adr_q[MR2_FORCE_BIT];
        write_termination_value_q    <= adr_q[MR2_WTRM_HI:MR2_WTRM_LO];
      end else if (ba_q == BA_MR3) begin
        src_q <= adr_q[MR3_SRC_BIT];
        sel_q <= adr_q[MR3_SEL_HI:MR3_SEL_LO];
      end else if (ba_q == BA_MR0) begin
        bl_q <= adr_q[MR0_BL_HI:MR0_BL_LO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Self-refresh rate
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      refresh_rate <= RATE_1X;
    end else if (forced_double_refresh_rate_q) begin
      refresh_rate <= RATE_2X;
    end else if (auto_temp_refresh_rate_q && temp_r) begin
      refresh_rate <= RATE_2X;
    end else begin
      refresh_rate <= RATE_1X;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst engine: writes hold termination, pattern reads drive data
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q    <= ST_IDLE;
      beat_q  <= '0;
      nbeat_q <= '0;
      bidx_q  <= '0;
    end else if (lclk_rise) begin
      case (st_q)
        ST_IDLE: begin
          if (cmd_q == CMD_WR) begin
            st_q    <= ST_WR;
            beat_q  <= '0;
            nbeat_q <= 4'(BEATS_BL8);
          end else if (is_read(cmd_q) && src_q && sel_q == MR3_SEL_CAL && dll_locked) begin
            st_q   <= ST_RD;
            beat_q <= '0;
            // burst length by MR0 or A12
            if (bl_q == BL_BC4 || (bl_q == BL_OTF && !adr_q[ADR_BC_BIT])) begin
              nbeat_q <= 4'(BEATS_BC4);
              bidx_q  <= adr_q[ADR_NIB_BIT] ? 3'(BEATS_BC4) : 3'h0;
            end else begin
              nbeat_q <= 4'(BEATS_BL8);
              bidx_q  <= 3'h0;
            end
          end
        end
        ST_WR, ST_RD: begin
          beat_q <= beat_q + 4'h1;
          bidx_q <= bidx_q + 3'h1;
          if (beat_q + 4'h1 == nbeat_q) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // normal mode: no pattern path; array not modelled, lines released
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dq_q  <= '0;
      oe_q  <= 1'b0;
      dqs_q <= 1'b0;
    end else begin
      oe_q  <= (st_q == ST_RD);
      dqs_q <= (st_q == ST_RD) & lclk_s;
      if (st_q == ST_RD) begin
        dq_q <= all_lines ? {DQ_W{CAL_PATTERN[bidx_q]}}
                          : DQ_W'(CAL_PATTERN[bidx_q]);
      end else begin
        dq_q <= '0;
      end
    end
  end
  assign link.dq_dev    = dq_q;
  assign link.dq_dev_oe = oe_q;
  assign link.dqs_dev   = dqs_q;

  ////////////////////////////////////////////////////////////////////////
  // Termination: write value in writes unless leveling, else nominal
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      term_active <= TERM_OFF;
    end else if (st_q == ST_WR && write_termination_value_q != TERM_OFF && !wlev_r) begin
      term_active <= write_termination_value_q;
    end else begin
      term_active <= nominal_termination_value;
    end
  end

  // flag commands other than reads and MR3 loads in pattern mode; reset still clears all
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ill_q <= 1'b0;
    end else if (lclk_rise && src_q && cmd_q != CMD_NOP) begin
      ill_q <= !is_read(cmd_q) && !(cmd_q == CMD_MRS && ba_q == BA_MR3);
    end else if (lclk_rise) begin
      ill_q <= 1'b0;
    end
  end
  assign cmd_illegal = ill_q;
  assign cal_mode    = src_q;
endmodule : mfl_dev

// *** core/mfl_link_if.sv ***
/*
  Link between controller end and device end: command, bank, address,
  a link clock made by the controller, and the data/strobe lines.
  Assumes the bench resolves two-way data lines from the enables.
*/
`timescale 1ns/1ps
interface mfl_link_if #(parameter int DQ_W = 8);
  import mfl_pkg::*;
  logic             lclk;
  logic [CMD_W-1:0] cmd;
  logic [BA_W-1:0]  ba;
  logic [ADR_W-1:0] adr;
  logic             wlev;
  logic [DQ_W-1:0]  dq_dev;
  logic             dq_dev_oe;
  logic             dqs_dev;

  modport ctrl (output lclk, cmd, ba, adr, wlev, input dq_dev, dq_dev_oe, dqs_dev);
  modport dev  (input lclk, cmd, ba, adr, wlev, output dq_dev, dq_dev_oe, dqs_dev);
endinterface : mfl_link_if

// *** core/mfl_pkg.sv ***
/*
  Shared constants for the mode-register-2/3 feature logic: mode register
  field positions, bank codes, command codes and burst figures.
  Assumes both ends compile this package first.
*/
package mfl_pkg;
  localparam int BA_W  = 3;
  localparam int ADR_W = 14;
  localparam int CMD_W = 3;

  // Bank address codes of the mode-register-set command
  localparam logic [BA_W-1:0] BA_MR0 = 3'h0;
  localparam logic [BA_W-1:0] BA_MR2 = 3'h2;
  localparam logic [BA_W-1:0] BA_MR3 = 3'h3;

  // Command codes on the link
  localparam logic [CMD_W-1:0] CMD_NOP  = 3'h0;
  localparam logic [CMD_W-1:0] CMD_MRS  = 3'h1;
  localparam logic [CMD_W-1:0] CMD_RD   = 3'h2;
  localparam logic [CMD_W-1:0] CMD_RDAP = 3'h3;
  localparam logic [CMD_W-1:0] CMD_WR   = 3'h4;
  localparam logic [CMD_W-1:0] CMD_PD   = 3'h5;
  localparam logic [CMD_W-1:0] CMD_SREF = 3'h6;

  // Mode register 2 fields
  localparam int MR2_AUTO_BIT  = 6;
  localparam int MR2_FORCE_BIT = 7;
  localparam int MR2_WTRM_LO  = 9;
  localparam int MR2_WTRM_HI  = 10;
  // Mode register 3 fields
  localparam int MR3_SRC_BIT  = 2;
  localparam int MR3_SEL_LO   = 0;
  localparam int MR3_SEL_HI   = 1;
  localparam logic [1:0] MR3_SEL_CAL = 2'h0;
  // Mode register 0 burst field: 00 fixed 8, 01 on the fly, 10 chop 4
  localparam int MR0_BL_LO = 0;
  localparam int MR0_BL_HI = 1;
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_BC4  = 2'h2;
  // Address bits used in pattern reads
  localparam int ADR_NIB_BIT = 2;
  localparam int ADR_BC_BIT  = 12;

  localparam int BEATS_BL8 = 8;
  localparam int BEATS_BC4 = 4;
  // Predefined calibration pattern, beat 0 in bit 0
  localparam logic [7:0] CAL_PATTERN = 8'hAA;
  // Rate codes of self refresh
  localparam logic [1:0] RATE_1X = 2'h1;
  localparam logic [1:0] RATE_2X = 2'h2;
  // Termination codes; zero is off / high impedance
  localparam logic [1:0] TERM_OFF = 2'h0;
endpackage : mfl_pkg

// *** core/mfl_sync.sv ***
/*
  Two-stage synchroniser with rising-edge flag on the settled value.
  Assumes the input comes from outside the mclk domain.
*/
`timescale 1ns/1ps
module mfl_sync (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout,
  output logic      rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // First stage read only by second
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign dout = s2_q;
  assign rise = s2_q & ~s3_q;
endmodule : mfl_sync

// *** verif/mfl_monitor.sv ***
/*
  Checker on the link between controller and device ends.
  Assumes mclk and sys_rst are shared by both ends and the link.
*/
`timescale 1ns/1ps
module mfl_monitor #(
  parameter int DQ_W = 8,
  parameter int DIV  = 4
) (
  input wire logic                      mclk,
  input wire logic                      sys_rst,
  input wire logic                      lclk,
  input wire logic [mfl_pkg::CMD_W-1:0] cmd,
  input wire logic [mfl_pkg::BA_W-1:0]  ba,
  input wire logic [mfl_pkg::ADR_W-1:0] adr,
  input wire logic                      wlev,
  input wire logic [DQ_W-1:0]           dq_dev,
  input wire logic                      dq_dev_oe,
  input wire logic                      dqs_dev
);
  import mfl_pkg::*;
  // One link cycle in mclk cycles
  localparam int LP = 2 * DIV;
  logic        lclk_q;
  logic        lrise;
  logic        cal_q;
  logic [15:0] oe_cnt_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    lclk_q <= sys_rst ? 1'h0 : lclk;
  end
  assign lrise = lclk && !lclk_q;

  // Pattern mode tracked from the wire, not from the device
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cal_q <= 1'h0;
    end else if (lrise && cmd == CMD_MRS && ba == BA_MR3) begin
      cal_q <= adr[MR3_SRC_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    oe_cnt_q <= (sys_rst || !dq_dev_oe) ? 16'h0 : oe_cnt_q + 16'h1;
  end

  ////////////////////////////////////////////////////////////
  property p_first_beat_low;
    $rose(dq_dev_oe) |-> !dq_dev[0];
  endproperty
  a_first_beat_low: assert property (p_first_beat_low)
    else $error("pattern burst does not start with zero");

  property p_beats_alternate;
    dq_dev_oe && $past(dq_dev_oe) && $changed(dq_dev) |-> dq_dev[0] != $past(dq_dev[0]);
  endproperty
  a_beats_alternate: assert property (p_beats_alternate)
    else $error("pattern beats do not alternate");

  property p_other_lines;
    dq_dev_oe |-> ((dq_dev >> 1) == {DQ_W{1'h0}}) || (dq_dev == {DQ_W{dq_dev[0]}});
  endproperty
  a_other_lines: assert property (p_other_lines)
    else $error("non-prime data lines wrong");

  property p_burst_len;
    $fell(dq_dev_oe) |-> oe_cnt_q == 16'(BEATS_BL8 * LP) || oe_cnt_q == 16'(BEATS_BC4 * LP);
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("pattern burst length wrong");

  property p_oe_in_cal;
    $rose(dq_dev_oe) |-> cal_q;
  endproperty
  a_oe_in_cal: assert property (p_oe_in_cal)
    else $error("device drove data outside pattern mode");

  property p_only_reads;
    cal_q && lrise && cmd != CMD_NOP |->
      cmd == CMD_RD || cmd == CMD_RDAP || (cmd == CMD_MRS && ba == BA_MR3);
  endproperty
  a_only_reads: assert property (p_only_reads)
    else $error("non-read command in pattern mode");

  property p_mr3_reserved;
    cmd == CMD_MRS && ba == BA_MR3 |-> adr[13:3] == 11'h0;
  endproperty
  a_mr3_reserved: assert property (p_mr3_reserved)
    else $error("reserved bits set in mode register 3 load");

  property p_one_rate;
    cmd == CMD_MRS && ba == BA_MR2 |-> !(adr[MR2_AUTO_BIT] && adr[MR2_FORCE_BIT]);
  endproperty
  a_one_rate: assert property (p_one_rate)
    else $error("both refresh rate options set");

  property p_pattern_addr;
    cal_q && (cmd == CMD_RD || cmd == CMD_RDAP) |-> adr[1:0] == 2'h0;
  endproperty
  a_pattern_addr: assert property (p_pattern_addr)
    else $error("pattern read with low address bits set");

  property p_strobe_in_burst;
    dqs_dev |-> dq_dev_oe;
  endproperty
  a_strobe_in_burst: assert property (p_strobe_in_burst)
    else $error("strobe outside a pattern burst");
endmodule : mfl_monitor

// *** verif/test_mfl.sv ***
/*
  Testbench joining controller and device ends over the link.
  Assumes package, interface, both ends and the monitor compiled first.
*/
`timescale 1ns/1ps
module test_mfl;
  import mfl_pkg::*;
  localparam int DQ_W = 8;
  logic             mclk, sys_rst, req, req_wlev, busy, rd_valid, req_refused;
  logic             temp_over, all_lines, dll_locked, cal_mode, cmd_illegal;
  logic [CMD_W-1:0] req_cmd;
  logic [BA_W-1:0]  req_ba;
  logic [ADR_W-1:0] req_adr;
  logic [DQ_W-1:0]  rd_data;
  logic [1:0]       nominal_termination_value, refresh_rate, term_active;
  logic [DQ_W-1:0]  beats[$];
  logic [CMD_W-1:0] bad[4] = '{CMD_WR, CMD_PD, CMD_SREF, CMD_MRS};
  int               num_errors, checks, refusals;

  mfl_link_if #(.DQ_W(DQ_W)) link ();
  mfl_ctrl #(.DQ_W(DQ_W), .DIV(4)) mfl_ctrl_i (
    .mclk(mclk), .sys_rst(sys_rst), .link(link), .req(req), .req_cmd(req_cmd),
    .req_ba(req_ba), .req_adr(req_adr), .req_wlev(req_wlev), .busy(busy),
    .rd_data(rd_data), .rd_valid(rd_valid), .req_refused(req_refused));
  mfl_dev #(.DQ_W(DQ_W)) mfl_dev_i (
    .mclk(mclk), .sys_rst(sys_rst), .link(link), .temp_over(temp_over),
    .all_lines(all_lines), .nominal_termination_value(nominal_termination_value),
    .dll_locked(dll_locked), .refresh_rate(refresh_rate), .term_active(term_active),
    .cal_mode(cal_mode), .cmd_illegal(cmd_illegal));
  mfl_monitor #(.DQ_W(DQ_W), .DIV(4)) mfl_monitor_i (
    .mclk(mclk), .sys_rst(sys_rst), .lclk(link.lclk), .cmd(link.cmd), .ba(link.ba),
    .adr(link.adr), .wlev(link.wlev), .dq_dev(link.dq_dev), .dq_dev_oe(link.dq_dev_oe),
    .dqs_dev(link.dqs_dev));

  always #4 mclk = ~mclk;

  // Capture on the falling edge, clear of the launching edge
  always @(negedge mclk) begin
    if (rd_valid === 1'h1) begin
      beats.push_back(rd_data);
    end
    if (req_refused === 1'h1) begin
      refusals++;
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  task automatic issue(input logic [CMD_W-1:0] c, input logic [BA_W-1:0] b,
                       input logic [ADR_W-1:0] a, input logic w);
    int n;
    n = 0;
    @(posedge mclk);
    req      <= 1'h1;
    req_cmd  <= c;
    req_ba   <= b;
    req_adr  <= a;
    req_wlev <= w;
    @(posedge mclk);
    req <= 1'h0;
    settle(1);
    while (busy !== 1'h0 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    chk("busy release", 32'(n < 2000), 32'h1);
  endtask : issue

  task automatic pat_read(input logic [CMD_W-1:0] c, input logic [ADR_W-1:0] a, input int n);
    beats.delete();
    // Bank bits all set: ignored in pattern mode
    issue(c, 3'h7, a, 1'h0);
    settle(400);
    chk("beat count", 32'(beats.size()), 32'(n));
    foreach (beats[k]) begin
      chk("beat", 32'(beats[k]), all_lines ? 32'({DQ_W{k[0]}}) : 32'(k[0]));
    end
  endtask : pat_read

  task automatic rate_case(input logic [ADR_W-1:0] a, input logic t, input logic [1:0] e);
    @(posedge mclk);
    temp_over <= t;
    issue(CMD_MRS, BA_MR2, a, 1'h0);
    settle(20);
    chk("refresh rate", 32'(refresh_rate), 32'(e));
  endtask : rate_case

  task automatic term_case(input logic [1:0] wv, input logic [1:0] nom, input logic w,
                           input logic on);
    int hit;
    hit = 0;
    @(posedge mclk);
    nominal_termination_value <= nom;
    issue(CMD_MRS, BA_MR2, {3'h0, wv, 9'h0}, 1'h0);
    fork
      issue(CMD_WR, 3'h0, 14'h0, w);
      repeat (300) begin
        @(negedge mclk);
        hit += (term_active === wv);
      end
    join
    chk("write termination used", 32'(hit != 0), 32'(on));
    chk("termination at rest", 32'(term_active), 32'(nom));
  endtask : term_case

  ////////////////////////////////////////////////////////////
  initial begin
    int n;
    mclk = 1'h0;
    sys_rst = 1'h1;
    req = 1'h0;
    req_wlev = 1'h0;
    req_cmd = CMD_NOP;
    req_ba = 3'h0;
    req_adr = 14'h0;
    temp_over = 1'h0;
    all_lines = 1'h0;
    dll_locked = 1'h1;
    nominal_termination_value = 2'h0;
    num_errors = 0;
    checks = 0;
    refusals = 0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'h0;
    settle(1);
    chk("rate after reset", 32'(refresh_rate), 32'(RATE_1X));
    rate_case(14'h0000, 1'h1, RATE_1X);
    rate_case(14'h0040, 1'h0, RATE_1X);
    rate_case(14'h0040, 1'h1, RATE_2X);
    rate_case(14'h0080, 1'h0, RATE_2X);
    rate_case(14'h00C0, 1'h0, RATE_1X);
    term_case(2'h1, 2'h3, 1'h0, 1'h1);
    term_case(2'h1, 2'h3, 1'h1, 1'h0);
    term_case(2'h0, 2'h3, 1'h0, 1'h0);
    term_case(2'h2, 2'h0, 1'h0, 1'h1);
    issue(CMD_MRS, BA_MR0, {12'h0, BL_OTF}, 1'h0);
    pat_read(CMD_RD, 14'h3FF8, 0);
    // no bank open before pattern mode
    issue(CMD_MRS, BA_MR3, 14'h0004, 1'h0);
    settle(1);
    chk("pattern mode on", 32'(cal_mode), 32'h1);
    pat_read(CMD_RD, 14'h3FF8, BEATS_BL8);
    pat_read(CMD_RD, 14'h2FF8, BEATS_BC4);
    pat_read(CMD_RDAP, 14'h2FFF, BEATS_BC4);
    @(posedge mclk);
    dll_locked <= 1'h0;
    pat_read(CMD_RD, 14'h3FF8, 0);
    @(posedge mclk);
    dll_locked <= 1'h1;
    @(posedge mclk);
    all_lines <= 1'h1;
    pat_read(CMD_RD, 14'h1000, BEATS_BL8);
    foreach (bad[i]) begin
      n = refusals;
      issue(bad[i], BA_MR2, 14'h0, 1'h0);
      settle(4);
      chk("refused", 32'(refusals - n), 32'h1);
    end
    chk("device flag", 32'(cmd_illegal), 32'h0);
    issue(CMD_MRS, BA_MR3, 14'h0003, 1'h0);
    settle(1);
    chk("pattern mode off", 32'(cal_mode), 32'h0);
    pat_read(CMD_RD, 14'h1000, 0);
    issue(CMD_MRS, BA_MR0, {12'h0, BL_BC4}, 1'h0);
    issue(CMD_MRS, BA_MR3, 14'h0004, 1'h0);
    pat_read(CMD_RD, 14'h1000, BEATS_BC4);
    @(posedge mclk);
    sys_rst <= 1'h1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'h0;
    settle(1);
    chk("pattern mode after reset", 32'(cal_mode), 32'h0);
    end_sim();
  end

  // Whole run is some tens of microseconds
  initial begin
    #400_000;
    num_errors++;
    end_sim();
  end
endmodule : test_mfl
